// ==== logic/smsp_consts.svh ====
// constants for the serial master/slave port: register offsets, control fields, reset values
// assumes a 100 MHz core clock and the plain register port of the top module
`ifndef SMSP_CONSTS_SVH
`define SMSP_CONSTS_SVH

`define SMSP_OFS_STATUS 32'hffff0a00
`define SMSP_OFS_RECEIVE 32'hffff0a04
`define SMSP_OFS_TRANSMIT 32'hffff0a08
`define SMSP_OFS_DIVIDER 32'hffff0a0c
`define SMSP_OFS_CONTROL 32'hffff0a10

`define SMSP_CTL_RESET 16'h0000
`define SMSP_DIV_RESET 8'h00

`define SMSP_BIT_THR_HI 15
`define SMSP_BIT_THR_LO 14
`define SMSP_BIT_TX_FLUSH 13
`define SMSP_BIT_RX_FLUSH 12
`define SMSP_BIT_CONT 11
`define SMSP_BIT_LOOP 10
`define SMSP_BIT_SLV_OE 9
`define SMSP_BIT_RX_OVW 8
`define SMSP_BIT_ZERO 7
`define SMSP_BIT_WR_INIT 6
`define SMSP_BIT_LSB 5
`define SMSP_BIT_OPEN_DRAIN 4
`define SMSP_BIT_CPOL 3
`define SMSP_BIT_CPHA 2
`define SMSP_BIT_MASTER 1
`define SMSP_BIT_ENABLE 0

`define SMSP_FIFO_DEPTH 3'h4
`define SMSP_BYTE_BITS 4'h8

`endif

// ==== logic/smsp_pkg.sv ====
// types for the serial master/slave port
// assumes smsp_consts.svh is included by the design files
package smsp_pkg;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } smsp_bus_req_type;

    typedef struct packed {
        logic sclk;
        logic cs_b;
        logic mosi;
        logic miso;
    } smsp_pins_in_type;

    typedef struct packed {
        logic sclk;
        logic sclk_oe;
        logic cs_b;
        logic cs_b_oe;
        logic mosi;
        logic mosi_oe;
        logic miso;
        logic miso_oe;
    } smsp_pins_out_type;

    typedef enum logic [3:0] {
        SMSP_IDLE = 4'b0001,
        SMSP_LEAD = 4'b0010,
        SMSP_SHIFT = 4'b0100,
        SMSP_STALL = 4'b1000
    } smsp_state_type;

    typedef struct packed {
        logic [7:0] mem0;
        logic [7:0] mem1;
        logic [7:0] mem2;
        logic [7:0] mem3;
        logic [1:0] rd_ptr;
        logic [1:0] wr_ptr;
        logic [2:0] count;
    } smsp_fifo_state_type;

endpackage

// ==== logic/smsp_fifo.sv ====
// four-byte flip-flop FIFO used for both receive and transmit directions
// assumes nothing of the caller: a pop when empty is ignored; a push when full is dropped unless a pop comes in the same cycle
`timescale 1ns/10ps
`include "smsp_consts.svh"
module smsp_fifo
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic flush_i,
    input wire logic push_i,
    input wire logic [7:0] push_data_i,
    input wire logic pop_i,
    output logic [7:0] head_o,
    output logic [2:0] count_o
);
    import smsp_pkg::*;

    smsp_fifo_state_type st;
    smsp_fifo_state_type next_st;
    logic do_push;
    logic do_pop;

    function automatic logic [7:0] pick(input smsp_fifo_state_type s, input logic [1:0] i);
        logic [7:0] r;
        r = s.mem0;
        case (i)
            2'h1: r = s.mem1;
            2'h2: r = s.mem2;
            2'h3: r = s.mem3;
            default: r = s.mem0;
        endcase
        return r;
    endfunction

    assign head_o = pick(st, st.rd_ptr);
    assign count_o = st.count;

    always_comb
    begin
        next_st = st;
        do_pop = pop_i && (st.count != 3'h0);
        do_push = push_i && ((st.count != `SMSP_FIFO_DEPTH) || do_pop);
        if (do_push)
        begin
            case (st.wr_ptr)
                2'h0: next_st.mem0 = push_data_i;
                2'h1: next_st.mem1 = push_data_i;
                2'h2: next_st.mem2 = push_data_i;
                default: next_st.mem3 = push_data_i;
            endcase
            next_st.wr_ptr = st.wr_ptr + 2'h1;
        end
        if (do_pop)
        begin
            next_st.rd_ptr = st.rd_ptr + 2'h1;
        end
        next_st.count = st.count + {2'h0, do_push} - {2'h0, do_pop};
        if (flush_i)
        begin
            next_st.rd_ptr = 2'h0;
            next_st.wr_ptr = 2'h0;
            next_st.count = 3'h0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// ==== logic/smsp_top.sv ====
// serial master/slave port: register file, bit-rate divider, shifter and both FIFOs
// assumes a single 100 MHz clock; slave-mode pins are asynchronous and are synchronised here
//
// Notes on behaviour
// - eight bits out and in together
// - master clock is clk over 2*(1+divider)
// - launch on one edge, sample on other
// - slave exchanges bytes while select is low
// - master drives select low during transfers
// - status shows receive and transmit byte counts
// - excess flag when receive count exceeds threshold
// - overflow flag on byte into full FIFO
// - receive flag at threshold count when read starts transfers, transmit flag when write does
// - underflow flag on transmit with empty FIFO
// - summary flag on any event except underflow during receive flush, read clears
// - threshold code selects one to four bytes
// - transmit flush empties FIFO, ignores writes
// - receive flush drops data and events
// - continuous mode holds select while transmit bytes are queued; else stall
// - loopback ties data output to input
// - slave output drive enable and open drain
// - overwrite or discard when receive FIFO full
// - empty FIFO sends zero or last byte
// - write starts transfer or read does
// - bit order, clock polarity and phase select
// - master/slave select and port enable
`timescale 1ns/10ps
`include "smsp_consts.svh"
module smsp_top
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire smsp_pkg::smsp_bus_req_type bus_i,
    output logic [31:0] rdata_o,
    input wire smsp_pkg::smsp_pins_in_type pins_i,
    output smsp_pkg::smsp_pins_out_type pins_o
);
    import smsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [15:0] ctl;
        logic [7:0] div;
        logic rx_ovf;
        logic rx_irq;
        logic tx_irq;
        logic tx_uf;
        logic any_irq;
        smsp_state_type fsm;
        logic [7:0] div_cnt;
        logic half;
        logic [3:0] bit_cnt;
        logic [7:0] tx_sh;
        logic [7:0] rx_sh;
        logic [7:0] last_tx;
        logic [2:0] xfer_cnt;
        logic [2:0] rx_cnt;
        logic start_req;
        logic [2:0] sclk_sync;
        logic [2:0] cs_sync;
        logic [2:0] mosi_sync;
        logic [2:0] miso_sync;
        logic sclk_prev;
        logic cs_prev;
        logic [31:0] rdata;
        smsp_pins_out_type pins;
    } smsp_top_state_type;

    smsp_top_state_type st;
    smsp_top_state_type next_st;

    logic [7:0] rx_head;
    logic [2:0] rx_count;
    logic [7:0] tx_head;
    logic [2:0] tx_count;
    logic rx_push;
    logic [7:0] rx_push_data;
    logic rx_pop;
    logic tx_push;
    logic tx_pop;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // a change counts once the second and third stages agree
    function automatic logic settled(input logic [2:0] s, input logic prev);
        return (s[1] == s[2]) ? s[2] : prev;
    endfunction

    function automatic logic [2:0] thr_bytes(input logic [15:0] c);
        return {1'b0, c[`SMSP_BIT_THR_HI:`SMSP_BIT_THR_LO]} + 3'h1;
    endfunction

    function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
        return lsb ? sh[0] : sh[7];
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic lsb);
        return lsb ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction

    function automatic logic [7:0] shift_out(input logic [7:0] sh, input logic lsb);
        return lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // FIFOs

    smsp_fifo u_rx_fifo
    (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .flush_i(st.ctl[`SMSP_BIT_RX_FLUSH]),
        .push_i(rx_push),
        .push_data_i(rx_push_data),
        .pop_i(rx_pop),
        .head_o(rx_head),
        .count_o(rx_count)
    );

    smsp_fifo u_tx_fifo
    (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .flush_i(st.ctl[`SMSP_BIT_TX_FLUSH]),
        .push_i(tx_push),
        .push_data_i(bus_i.wdata[7:0]),
        .pop_i(tx_pop),
        .head_o(tx_head),
        .count_o(tx_count)
    );

    assign rdata_o = st.rdata;
    assign pins_o = st.pins;

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        logic en;
        logic master;
        logic cpol;
        logic cpha;
        logic lsb;
        logic s_sclk;
        logic s_cs;
        logic s_din;
        logic lead;
        logic trail;
        logic samp;
        logic launch;
        logic byte_done;
        logic load;
        logic [7:0] load_val;
        logic st_rd;
        logic rx_rd;
        logic ev_ovf;
        logic ev_rx;
        logic ev_tx;
        logic ev_uf;
        logic dout;
        logic [2:0] next_rx_cnt;
        en = 1'b0;
        master = 1'b0;
        cpol = 1'b0;
        cpha = 1'b0;
        lsb = 1'b0;
        s_sclk = 1'b0;
        s_cs = 1'b1;
        s_din = 1'b0;
        lead = 1'b0;
        trail = 1'b0;
        samp = 1'b0;
        launch = 1'b0;
        byte_done = 1'b0;
        load = 1'b0;
        load_val = 8'h00;
        st_rd = 1'b0;
        rx_rd = 1'b0;
        ev_ovf = 1'b0;
        ev_rx = 1'b0;
        ev_tx = 1'b0;
        ev_uf = 1'b0;
        dout = 1'b0;
        next_rx_cnt = 3'h0;
        next_st = st;
        rx_push = 1'b0;
        rx_push_data = st.rx_sh;
        rx_pop = 1'b0;
        tx_push = 1'b0;
        tx_pop = 1'b0;

        en = st.ctl[`SMSP_BIT_ENABLE];
        master = st.ctl[`SMSP_BIT_MASTER];
        cpol = st.ctl[`SMSP_BIT_CPOL];
        cpha = st.ctl[`SMSP_BIT_CPHA];
        lsb = st.ctl[`SMSP_BIT_LSB];

        // three-stage synchronisers for pins from the far side
        next_st.sclk_sync = {st.sclk_sync[1:0], pins_i.sclk};
        next_st.cs_sync = {st.cs_sync[1:0], pins_i.cs_b};
        next_st.mosi_sync = {st.mosi_sync[1:0], pins_i.mosi};
        next_st.miso_sync = {st.miso_sync[1:0], pins_i.miso};
        s_sclk = settled(st.sclk_sync, st.sclk_prev);
        s_cs = settled(st.cs_sync, st.cs_prev);
        next_st.sclk_prev = s_sclk;
        next_st.cs_prev = s_cs;

        // loopback feeds our own data output back as input
        if (st.ctl[`SMSP_BIT_LOOP])
        begin
            s_din = master ? st.pins.mosi : st.pins.miso;
        end
        else
        begin
            s_din = master ? st.miso_sync[2] : st.mosi_sync[2];
        end

        ////////////////////////////////////////////////////////////////////////
        // register port
        next_st.rdata = 32'h0000_0000;
        if (bus_i.rd)
        begin
            unique case (bus_i.addr)
                `SMSP_OFS_STATUS:
                begin
                    st_rd = 1'b1;
                    next_st.rdata = {20'h00000,
                        (rx_count > thr_bytes(st.ctl)), rx_count,
                        st.rx_ovf, st.rx_irq, st.tx_irq, st.tx_uf, tx_count, st.any_irq};
                end
                `SMSP_OFS_RECEIVE:
                begin
                    rx_rd = 1'b1;
                    next_st.rdata = {24'h000000, rx_head};
                    rx_pop = 1'b1;
                end
                `SMSP_OFS_DIVIDER: next_st.rdata = {24'h000000, st.div};
                `SMSP_OFS_CONTROL: next_st.rdata = {16'h0000, st.ctl};
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
        if (bus_i.wr)
        begin
            if (bus_i.addr == `SMSP_OFS_CONTROL)
            begin
                next_st.ctl = bus_i.wdata[15:0];
            end
            if (bus_i.addr == `SMSP_OFS_DIVIDER)
            begin
                next_st.div = bus_i.wdata[7:0];
            end
            if ((bus_i.addr == `SMSP_OFS_TRANSMIT) && !st.ctl[`SMSP_BIT_TX_FLUSH])
            begin
                tx_push = 1'b1;
            end
        end

        // start requests for master transfers
        if (en && master)
        begin
            if (st.ctl[`SMSP_BIT_WR_INIT] && tx_push)
            begin
                next_st.start_req = 1'b1;
            end
            if (!st.ctl[`SMSP_BIT_WR_INIT] && rx_rd)
            begin
                next_st.start_req = 1'b1;
            end
        end
        else
        begin
            next_st.start_req = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////////
        // shifter
        if (!en)
        begin
            next_st.fsm = SMSP_IDLE;
            next_st.bit_cnt = 4'h0;
            next_st.pins.sclk = cpol;
            next_st.pins.cs_b = 1'b1;
        end
        else if (master)
        begin
            unique case (st.fsm)
                SMSP_IDLE:
                begin
                    next_st.pins.sclk = cpol;
                    next_st.pins.cs_b = 1'b1;
                    if (st.start_req || (st.ctl[`SMSP_BIT_WR_INIT] && tx_count != 3'h0))
                    begin
                        load = 1'b1;
                        next_st.start_req = 1'b0;
                        next_st.pins.cs_b = 1'b0;
                        next_st.fsm = SMSP_LEAD;
                    end
                end
                SMSP_LEAD, SMSP_SHIFT:
                begin
                    // one half period spans 1+divider core clocks
                    if (st.div_cnt == st.div)
                    begin
                        next_st.div_cnt = 8'h00;
                        next_st.half = ~st.half;
                        next_st.pins.sclk = ~st.pins.sclk;
                        next_st.fsm = SMSP_SHIFT;
                        lead = !st.half;
                        trail = st.half;
                    end
                    else
                    begin
                        next_st.div_cnt = st.div_cnt + 8'h01;
                    end
                end
                SMSP_STALL:
                begin
                    // return the clock to idle a half period on, then raise select a half period after that
                    if (st.div_cnt == st.div)
                    begin
                        next_st.div_cnt = 8'h00;
                        next_st.half = ~st.half;
                        next_st.pins.sclk = cpol;
                        if (st.half)
                        begin
                            next_st.pins.cs_b = 1'b1;
                            next_st.fsm = SMSP_IDLE;
                        end
                    end
                    else
                    begin
                        next_st.div_cnt = st.div_cnt + 8'h01;
                    end
                end
                default: next_st.fsm = SMSP_IDLE;
            endcase
        end
        else
        begin
            // slave: edges come from the external master
            next_st.fsm = s_cs ? SMSP_IDLE : SMSP_SHIFT;
            lead = !s_cs && (s_sclk != st.sclk_prev) && (s_sclk != cpol);
            trail = !s_cs && (s_sclk != st.sclk_prev) && (s_sclk == cpol);
            if (!s_cs && st.cs_prev)
            begin
                load = 1'b1;
                next_st.bit_cnt = 4'h0;
            end
        end

        // phase 0 samples on the leading edge, phase 1 on the trailing one
        samp = cpha ? trail : lead;
        launch = cpha ? lead : trail;
        if (samp)
        begin
            next_st.rx_sh = shift_in(st.rx_sh, s_din, lsb);
            next_st.bit_cnt = st.bit_cnt + 4'h1;
            byte_done = (st.bit_cnt + 4'h1) == `SMSP_BYTE_BITS;
        end
        // the first bit is already on the pin, so nothing launches before the first sample
        if (launch && st.bit_cnt != 4'h0)
        begin
            next_st.tx_sh = shift_out(st.tx_sh, lsb);
        end

        // byte completion
        if (byte_done)
        begin
            next_st.bit_cnt = 4'h0;
            rx_push_data = shift_in(st.rx_sh, s_din, lsb);
            if (!st.ctl[`SMSP_BIT_RX_FLUSH])
            begin
                if (rx_count == `SMSP_FIFO_DEPTH && !rx_pop)
                begin
                    ev_ovf = 1'b1;
                    rx_push = st.ctl[`SMSP_BIT_RX_OVW];
                    rx_pop = st.ctl[`SMSP_BIT_RX_OVW];
                end
                else
                begin
                    rx_push = 1'b1;
                end
                next_rx_cnt = st.rx_cnt + 3'h1;
                if (!st.ctl[`SMSP_BIT_WR_INIT] && next_rx_cnt >= thr_bytes(st.ctl))
                begin
                    ev_rx = 1'b1;
                    next_rx_cnt = 3'h0;
                end
                next_st.rx_cnt = next_rx_cnt;
            end
            next_st.xfer_cnt = st.xfer_cnt + 3'h1;
            if (st.ctl[`SMSP_BIT_WR_INIT] && (st.xfer_cnt + 3'h1) >= thr_bytes(st.ctl))
            begin
                ev_tx = 1'b1;
                next_st.xfer_cnt = 3'h0;
            end
            if (master)
            begin
                if (st.ctl[`SMSP_BIT_CONT] && tx_count != 3'h0)
                begin
                    load = 1'b1;
                end
                else
                begin
                    next_st.fsm = SMSP_STALL;
                    next_st.half = 1'b0;
                    next_st.div_cnt = 8'h00;
                end
            end
            else
            begin
                load = 1'b1;
            end
        end

        // fetch the next byte, or the fill value when none is queued
        if (load)
        begin
            if (tx_count != 3'h0)
            begin
                load_val = tx_head;
                tx_pop = 1'b1;
            end
            else
            begin
                ev_uf = !st.ctl[`SMSP_BIT_TX_FLUSH];
                load_val = st.ctl[`SMSP_BIT_ZERO] ? 8'h00 : st.last_tx;
            end
            next_st.tx_sh = load_val;
            next_st.last_tx = load_val;
            next_st.half = 1'b0;
            next_st.div_cnt = 8'h00;
        end

        // sticky flags: an event in the read cycle wins over the clear
        next_st.rx_ovf = ev_ovf || (st.rx_ovf && !st_rd);
        next_st.rx_irq = ev_rx || (st.rx_irq && !st_rd);
        next_st.tx_irq = ev_tx || (st.tx_irq && !st_rd);
        next_st.tx_uf = ev_uf || (st.tx_uf && !st_rd);
        next_st.any_irq = ((ev_ovf || ev_uf) && !st.ctl[`SMSP_BIT_RX_FLUSH]) || ev_rx || ev_tx
            || (st.any_irq && !st_rd);

        ////////////////////////////////////////////////////////////////////////
        // pin drivers
        dout = out_bit(load ? load_val : next_st.tx_sh, lsb);
        next_st.pins.sclk_oe = en && master;
        next_st.pins.cs_b_oe = en && master;
        next_st.pins.mosi = dout;
        next_st.pins.miso = dout;
        if (st.ctl[`SMSP_BIT_OPEN_DRAIN])
        begin
            next_st.pins.mosi_oe = en && master && !dout;
            next_st.pins.miso_oe = en && !master && !s_cs && !dout;
        end
        else
        begin
            next_st.pins.mosi_oe = en && master;
            next_st.pins.miso_oe = en && !master && !s_cs
                && (st.ctl[`SMSP_BIT_SLV_OE] || !dout);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st <= '0;
            st.ctl <= `SMSP_CTL_RESET;
            st.div <= `SMSP_DIV_RESET;
            st.fsm <= SMSP_IDLE;
            st.sclk_sync <= 3'h0;
            st.cs_sync <= 3'h7;
            st.cs_prev <= 1'b1;
            st.pins.cs_b <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// ==== test/smsp_properties.sv ====
// checker for the serial port: bus answers and master-mode pin timing
// assumes it is bound to smsp_top and sees only that module's ports
`timescale 1ns/10ps
`include "smsp_consts.svh"
module smsp_properties
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire smsp_pkg::smsp_bus_req_type bus_i,
    input wire logic [31:0] rdata_o,
    input wire smsp_pkg::smsp_pins_in_type pins_i,
    input wire smsp_pkg::smsp_pins_out_type pins_o
);
import smsp_pkg::*;
logic [15:0] ctl_q;
logic [15:0] ctl_d1_q;
logic [15:0] ctl_d2_q;
logic [7:0] div_q;
logic [7:0] cnt_q;
logic sclk_q;
logic seen_q;
logic tog;
logic stab;
logic mapped;
assign tog = pins_o.sclk != sclk_q;
// pins follow the control register a cycle or two late
assign stab = ctl_q == ctl_d1_q && ctl_d1_q == ctl_d2_q;
assign mapped = bus_i.addr inside {`SMSP_OFS_STATUS, `SMSP_OFS_RECEIVE, `SMSP_OFS_TRANSMIT,
    `SMSP_OFS_DIVIDER, `SMSP_OFS_CONTROL};
always_ff @(posedge clk_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        ctl_q <= 16'h0000;
        ctl_d1_q <= 16'h0000;
        ctl_d2_q <= 16'h0000;
        div_q <= 8'h00;
        cnt_q <= 8'h00;
        sclk_q <= 1'b0;
        seen_q <= 1'b0;
    end
    else
    begin
        ctl_q <= (bus_i.wr && bus_i.addr == `SMSP_OFS_CONTROL) ? bus_i.wdata[15:0] : ctl_q;
        div_q <= (bus_i.wr && bus_i.addr == `SMSP_OFS_DIVIDER) ? bus_i.wdata[7:0] : div_q;
        ctl_d1_q <= ctl_q;
        ctl_d2_q <= ctl_d1_q;
        sclk_q <= pins_o.sclk;
        // a wrapped count only matters while idle, where it is never checked
        cnt_q <= tog ? 8'h00 : cnt_q + 8'h01;
        seen_q <= pins_o.cs_b ? 1'b0 : (tog ? 1'b1 : seen_q);
    end
end
////////////////////////////////////////////////////////////////////////////////
default clocking @(posedge clk_i); endclocking
default disable iff (!rst_b_i);
a_rdata_quiet:
    assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0)
        else $error("read data not zero outside a read answer");
a_unmapped_zero:
    assert property (bus_i.rd && !mapped |=> rdata_o == 32'h0)
        else $error("unmapped read returned nonzero data");
a_div_readback:
    assert property (bus_i.rd && bus_i.addr == `SMSP_OFS_DIVIDER |=> rdata_o == {24'h0, div_q})
        else $error("divider read differs from last write");
a_ctl_readback:
    assert property (bus_i.rd && bus_i.addr == `SMSP_OFS_CONTROL |=> rdata_o == {16'h0, ctl_q})
        else $error("control read differs from last write");
a_disabled_idle:
    assert property (!ctl_q[0] && stab |-> pins_o.cs_b && pins_o.sclk == ctl_q[3])
        else $error("disabled port not idle");
a_master_pins:
    assert property (ctl_q[1:0] == 2'b11 && stab |-> pins_o.sclk_oe && pins_o.cs_b_oe && !pins_o.miso_oe)
        else $error("master mode pin drivers wrong");
a_sclk_rate:
    assert property (tog && seen_q && !pins_o.cs_b && pins_o.sclk_oe |-> cnt_q == div_q)
        else $error("serial clock half period differs from divider");
a_idle_clock:
    assert property (stab && pins_o.sclk_oe && pins_o.cs_b && $past(pins_o.cs_b)
        |-> pins_o.sclk == ctl_q[3])
        else $error("serial clock not at idle level between transfers");
endmodule

bind smsp_top smsp_properties u_smsp_properties (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .pins_i(pins_i), .pins_o(pins_o));

// ==== test/smsp_slave_model.sv ====
// slave device on the far side of the port while the port is master
// assumes the port drives clock, select and data out; phase and polarity come from the bench
`timescale 1ns/10ps
module smsp_slave_model
(
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic mosi_i,
    input wire logic cpol_i,
    input wire logic cpha_i,
    input wire logic [7:0] reply_i,
    output logic miso_o,
    output logic [7:0] got_o
);
logic [7:0] txs;
initial
begin
    miso_o = 1'b0;
    got_o = 8'h00;
    txs = 8'h00;
end
// a deselected slave floats its line; the inverse keeps stale bits from matching
always @(posedge cs_b_i)
begin
    miso_o = ~miso_o;
end
always @(negedge cs_b_i)
begin
    txs = reply_i;
    if (!cpha_i)
    begin
        miso_o = txs[7];
        txs = txs << 1;
    end
end
always @(sclk_i)
begin
    if (!cs_b_i)
    begin
        if ((sclk_i != cpol_i) ^ cpha_i)
            got_o = {got_o[6:0], mosi_i};
        else
        begin
            miso_o = txs[7];
            txs = txs << 1;
        end
    end
end
endmodule

// ==== test/smsp_top_tb.sv ====
// self-checking bench for the serial port: register access and master-mode exchange
// assumes the slave model on the far side and the checker bound to the top
`timescale 1ns/10ps
`include "smsp_consts.svh"
module smsp_top_tb;
import smsp_pkg::*;
logic clk_i = 1'b0;
logic rst_b_i = 1'b0;
smsp_bus_req_type bus_i = '0;
logic [31:0] rdata_o;
smsp_pins_in_type pins_i;
smsp_pins_out_type pins_o;
logic miso;
logic cpol = 1'b0;
logic cpha = 1'b0;
logic [7:0] got;
logic [7:0] reply = 8'h00;
logic [31:0] d;
int n_fail = 0;
int n_compared = 0;
int cycles = 0;
assign pins_i = '{sclk: pins_o.sclk, cs_b: pins_o.cs_b, mosi: pins_o.mosi, miso: miso};
smsp_top u_smsp_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .pins_i(pins_i), .pins_o(pins_o));
smsp_slave_model u_smsp_slave_model (.sclk_i(pins_o.sclk), .cs_b_i(pins_o.cs_b),
    .mosi_i(pins_o.mosi), .cpol_i(cpol), .cpha_i(cpha), .reply_i(reply), .miso_o(miso),
    .got_o(got));
always #5 clk_i = ~clk_i;
////////////////////////////////////////////////////////////////////////////////
task summarize;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
always @(posedge clk_i)
begin
    cycles++;
    if (cycles == 20000)
    begin
        n_fail++;
        summarize();
    end
end
function automatic logic [7:0] rev(input logic [7:0] x);
    return {<<{x}};
endfunction
task chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
        n_fail++;
        $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
endtask
task wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk_i);
    bus_i <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
endtask
task rchk(input string name, input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    bus_i <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_i);
    bus_i.rd <= 1'b0;
    #1 d = rdata_o;
    chk(name, exp, d);
endtask
// bounded waits: a transfer that never starts shows up in the data checks
task xfer(input logic [7:0] tx);
    int i;
    wr(`SMSP_OFS_TRANSMIT, {24'h0, tx});
    for (i = 0; i < 50 && pins_o.cs_b; i++) @(posedge clk_i);
    for (i = 0; i < 500 && !pins_o.cs_b; i++) @(posedge clk_i);
    repeat (20) @(posedge clk_i);
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    logic [2:0] m;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rchk("status", `SMSP_OFS_STATUS, 32'h0);
    rchk("control", `SMSP_OFS_CONTROL, 32'h0);
    rchk("unmapped", 32'hffff0a14, 32'h0);
    wr(`SMSP_OFS_DIVIDER, 32'h3);
    rchk("divider", `SMSP_OFS_DIVIDER, 32'h3);
    // every polarity, phase and bit order, write-initiated master
    for (int k = 0; k < 8; k++)
    begin
        m = k[2:0];
        cpol = m[0];
        cpha = m[1];
        reply = 8'hc1 ^ {5'h0, m};
        wr(`SMSP_OFS_CONTROL, {26'h0, m[2], 1'b0, m[0], m[1], 2'b11} | 32'h40);
        xfer(8'h5a + {5'h0, m});
        chk("slave byte", {24'h0, m[2] ? rev(8'h5a + {5'h0, m}) : 8'h5a + {5'h0, m}},
            {24'h0, got});
        rchk("status", `SMSP_OFS_STATUS, 32'h121);
        rchk("receive", `SMSP_OFS_RECEIVE, {24'h0, m[2] ? rev(reply) : reply});
    end
    cpol = 1'b0;
    cpha = 1'b0;
    wr(`SMSP_OFS_CONTROL, 32'h43);
    for (int k = 0; k < 5; k++)
    begin
        reply = k[7:0];
        xfer(8'h10);
    end
    rchk("status", `SMSP_OFS_STATUS, 32'hca1);
    rchk("receive", `SMSP_OFS_RECEIVE, 32'h0);
    rchk("status", `SMSP_OFS_STATUS, 32'hb00);
    wr(`SMSP_OFS_CONTROL, 32'hc043);
    rchk("status", `SMSP_OFS_STATUS, 32'h300);
    wr(`SMSP_OFS_CONTROL, 32'h2043);
    wr(`SMSP_OFS_TRANSMIT, 32'h77);
    @(posedge clk_i);
    rchk("status", `SMSP_OFS_STATUS, 32'hb00);
    wr(`SMSP_OFS_CONTROL, 32'h0443);
    for (int k = 1; k < 4; k++)
        rchk("receive", `SMSP_OFS_RECEIVE, k);
    xfer(8'h3e);
    rchk("receive", `SMSP_OFS_RECEIVE, 32'h3e);
    wr(`SMSP_OFS_CONTROL, 32'h0);
    repeat (4) @(posedge clk_i);
    summarize();
end
endmodule
